// file: rtl/qed_pkg.sv
// Purpose: Shared constants for the quad edge register with common clear
// Assumes: One 50 MHz system clock, synchronous active-high reset
// Notes:   Pin-side levels pass a three-stage filter before use
package qed_pkg;

  // Number of storage elements
  localparam int unsigned QED_CHANNELS = 4;

  // Clock rate in kHz, kept for derived timing figures
  localparam int unsigned QED_CLK_KHZ = 50000;

  // Stored bits after reset or clear: true low, inverted high
  localparam logic QED_TRUE_RESET = 1'h0;
  localparam logic QED_INV_RESET  = 1'h1;

  // Filter reset levels: capture clock idles high, clear asserted
  localparam logic QED_CLK_IDLE   = 1'h1;
  localparam logic QED_CLR_IDLE   = 1'h0;
  localparam logic QED_DATA_IDLE  = 1'h0;

endpackage : qed_pkg

// file: rtl/qed_pin_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for pin levels
// Assumes: Inputs are asynchronous to clock_i
// Notes:   Filtered level moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module qed_pin_sync #(
  parameter int unsigned WIDTH      = 1,
  parameter logic        IDLE_LEVEL = 1'h0
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  // Pin side
  input  wire logic [WIDTH-1:0] pin_i,
  // Filtered level
  output logic      [WIDTH-1:0] level_o
);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("qed_pin_sync: WIDTH must be at least 1");
    end
  endgenerate

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      logic stage1_r;
      logic stage2_r;
      logic stage3_r;
      logic level_r;

      // First stage feeds only the second stage
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          stage1_r <= IDLE_LEVEL;
          stage2_r <= IDLE_LEVEL;
          stage3_r <= IDLE_LEVEL;
        end
        else
        begin
          stage1_r <= pin_i[b];
          stage2_r <= stage1_r;
          stage3_r <= stage2_r;
        end
      end

      // Accept a change only once two settled stages agree
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          level_r <= IDLE_LEVEL;
        end
        else if (stage2_r == stage3_r)
        begin
          level_r <= stage3_r;
        end
      end

      assign level_o[b] = level_r;
    end
  endgenerate

endmodule // qed_pin_sync

`default_nettype wire

// file: rtl/qed_quad_reg.sv
// Purpose: Four edge-captured storage bits with shared capture clock and clear
// Assumes: Capture clock, clear and data arrive on pins, asynchronous to clock_i
// Notes:   Pin rates must stay well below clock_i; every pin sees equal latency
//          Outputs move five clock_i edges after a capture clock pin rises
//          Clear acts five edges after its pin falls, not at once as on a plain flop
//          Pulses shorter than two cycles on any pin may be lost in the filter
//          Data should stand three cycles before a capture rise and one after
//          Reset needs only one cycle: it loads every filter stage directly
//          Clear and a capture rise in the same filtered cycle: clear wins
//
// Function
// - Each capture clock rising edge while clear is high stores all four data inputs and shows them.
// - One common capture clock and one common clear serve all four elements.
// - Clear low forces true outputs low and inverted outputs high.
// - Each element drives a true output and its exact complement.
// - Clear high: after a rising edge, outputs follow the sampled data level.
`timescale 1ns/1ps
`default_nettype none

module qed_quad_reg
#(
  parameter int unsigned CHANNELS = qed_pkg::QED_CHANNELS
) (
  // System clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  // Pin-side controls
  input  wire logic                capture_clock_i,
  input  wire logic                common_clear_n_i,
  // Pin-side data
  input  wire logic [CHANNELS-1:0] sample_inputs_i,
  // Stored outputs
  output logic      [CHANNELS-1:0] true_outputs_o,
  output logic      [CHANNELS-1:0] inverted_outputs_o
);

  import qed_pkg::*;

  generate
    if (CHANNELS < 1)
    begin : g_bad_channels
      $error("qed_quad_reg: CHANNELS must be at least 1");
    end
  endgenerate

  // Both reset levels equal would leave the pair equal, not complementary, after clear
  generate
    if (QED_TRUE_RESET == QED_INV_RESET)
    begin : g_bad_reset_pair
      $error("qed_quad_reg: reset levels of the two outputs must differ");
    end
  endgenerate

  // A low clock idle would turn a high pin at release into a false capture
  generate
    if (!QED_CLK_IDLE)
    begin : g_bad_clk_idle
      $error("qed_quad_reg: capture clock filter must idle high");
    end
  endgenerate

  // Clear starts asserted so nothing is stored before the pin is seen
  generate
    if (QED_CLR_IDLE)
    begin : g_bad_clr_idle
      $error("qed_quad_reg: clear filter must idle asserted");
    end
  endgenerate

  // Filtered pin levels
  logic                clk_level;
  logic                clr_n_level;
  logic [CHANNELS-1:0] data_level;

  // Edge detect and control decode
  logic                clk_prev_r;
  logic                capture_rise;
  logic                clear_now;
  logic                capture_now;

  // Data and controls share one filter depth, so their relative timing
  // at the pins is preserved inside
  // Single capture clock filter
  qed_pin_sync #(
    .WIDTH      (1),
    .IDLE_LEVEL (QED_CLK_IDLE)
  ) u_clk_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .pin_i   (capture_clock_i),
    .level_o (clk_level)
  );

  qed_pin_sync #(
    .WIDTH      (1),
    .IDLE_LEVEL (QED_CLR_IDLE)
  ) u_clr_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .pin_i   (common_clear_n_i),
    .level_o (clr_n_level)
  );

  // All data pins share one filter
  qed_pin_sync #(
    .WIDTH      (CHANNELS),
    .IDLE_LEVEL (QED_DATA_IDLE)
  ) u_data_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .pin_i   (sample_inputs_i),
    .level_o (data_level)
  );

  // Previous level resets high so a clock already high is no false edge
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      clk_prev_r <= QED_CLK_IDLE;
    end
    else
    begin
      clk_prev_r <= clk_level;
    end
  end

  assign capture_rise = clk_level & ~clk_prev_r;

  always_comb
  begin
    clear_now = 1'h0;
    if (!clr_n_level)
    begin
      clear_now = 1'h1;
    end
  end

  always_comb
  begin
    capture_now = 1'h0;
    if (capture_rise && !clear_now)
    begin
      capture_now = 1'h1;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_elem
      // Stored bit and its complement
      logic true_r;
      logic true_nxt;
      logic inv_r;
      logic inv_nxt;

      always_comb
      begin
        true_nxt = true_r;
        if (clear_now)
        begin
          true_nxt = QED_TRUE_RESET;
        end
        else if (capture_now)
        begin
          true_nxt = data_level[ch];
        end
      end

      always_comb
      begin
        inv_nxt = inv_r;
        if (clear_now)
        begin
          inv_nxt = QED_INV_RESET;
        end
        else if (capture_now)
        begin
          inv_nxt = ~data_level[ch];
        end
      end

      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          true_r <= QED_TRUE_RESET;
        end
        else
        begin
          true_r <= true_nxt;
        end
      end

      // Own flop for the complement so both outputs switch on one edge
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          inv_r <= QED_INV_RESET;
        end
        else
        begin
          inv_r <= inv_nxt;
        end
      end

      assign true_outputs_o[ch]     = true_r;
      assign inverted_outputs_o[ch] = inv_r;
    end
  endgenerate

endmodule // qed_quad_reg

`default_nettype wire

// file: sim/qed_src.sv
// Purpose: Capture clock source
// Assumes: pulse_i lasts one cycle
// Notes:   Pin stays high 4 cycles
`timescale 1ns/1ps
`default_nettype none
module qed_src (
  // Clock
  input  wire logic clock_i,
  // Request
  input  wire logic pulse_i,
  // Pin
  output wire logic capture_clock_o
);
  logic [2:0] cnt_r = 3'h0;
  always_ff @(posedge clock_i)
  begin
    cnt_r <= pulse_i ? 3'h4 : cnt_r - {2'h0, cnt_r != 3'h0};
  end
  assign capture_clock_o = cnt_r != 3'h0;
endmodule // qed_src
`default_nettype wire

// file: sim/qed_quad_reg_chk.sv
// Purpose: Port checks
// Assumes: Four to five edge pin latency
// Notes:   Windows allow filter slack
`timescale 1ns/1ps
`default_nettype none
module qed_quad_reg_chk #(
  parameter int unsigned CHANNELS = 4
) (
  // Clock and reset
  input wire logic                clock_i,
  input wire logic                reset_i,
  // Watched pins
  input wire logic                capture_clock_i,
  input wire logic                common_clear_n_i,
  input wire logic [CHANNELS-1:0] sample_inputs_i,
  // Watched outputs
  input wire logic [CHANNELS-1:0] true_outputs_o,
  input wire logic [CHANNELS-1:0] inverted_outputs_o
);
  logic       cap_r;
  logic [3:0] since_r;
  always_ff @(posedge clock_i)
  begin
    cap_r <= capture_clock_i;
    since_r <= reset_i ? 4'hf : (capture_clock_i & ~cap_r) ? 4'h0
             : since_r + {3'h0, since_r != 4'hf};
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  property cap_p;
    logic [CHANNELS-1:0] d;
    ((common_clear_n_i && $stable(sample_inputs_i)) [*6] ##0
     ($rose(capture_clock_i), d = sample_inputs_i) ##1
     (common_clear_n_i && $stable(sample_inputs_i)) [*5])
    |-> true_outputs_o == d && inverted_outputs_o == ~d;
  endproperty
  inv_complement_a: assert property (inverted_outputs_o == ~true_outputs_o)
    else $error("inverted not complement");
  clear_true_a: assert property (!common_clear_n_i [*6] |-> true_outputs_o == '0)
    else $error("true not cleared");
  clear_inv_a: assert property (!common_clear_n_i [*6] |-> inverted_outputs_o == '1)
    else $error("inverted not set");
  hold_idle_a: assert property (($stable(capture_clock_i) && common_clear_n_i) [*6]
    |-> $stable(true_outputs_o)) else $error("output moved between edges");
  capture_data_a: assert property (cap_p)
    else $error("capture wrong");
  common_edge_a: assert property ($changed(true_outputs_o) && true_outputs_o != '0
    |-> since_r inside {[4'h2:4'h6]}) else $error("change without edge");
  cover property ($rose(capture_clock_i) && common_clear_n_i);
  cover property (!common_clear_n_i [*6]);
  cover property ($changed(true_outputs_o));
endmodule // qed_quad_reg_chk
bind qed_quad_reg qed_quad_reg_chk #(.CHANNELS(CHANNELS)) u_chk (.clock_i, .reset_i,
  .capture_clock_i, .common_clear_n_i, .sample_inputs_i, .true_outputs_o,
  .inverted_outputs_o);
`default_nettype wire

// file: sim/tb_quad_edge_register_clear.sv
// Purpose: Self-checking bench
// Assumes: Default four channels
// Notes:   Model is one int
`timescale 1ns/1ps
`default_nettype none
module tb_quad_edge_register_clear;
  logic       clock_i = 1'h0;
  logic       reset_i = 1'h1;
  logic       pulse   = 1'h0;
  logic       clr_n   = 1'h0;
  logic [3:0] din     = 4'h0;
  wire logic       cap;
  wire logic [3:0] q;
  wire logic [3:0] qn;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 65699;
  int exp_q = 0;
  initial forever #10 clock_i = ~clock_i;
  qed_src u_src (.clock_i, .pulse_i(pulse), .capture_clock_o(cap));
  qed_quad_reg u_dut (.clock_i, .reset_i, .capture_clock_i(cap), .common_clear_n_i(clr_n),
    .sample_inputs_i(din), .true_outputs_o(q), .inverted_outputs_o(qn));
  task automatic chk(string nm, logic [3:0] seen, logic [3:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, want, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Data moves after the edge so a leaky hold shows up
  task automatic capture(logic [3:0] d);
    din <= d;
    cyc(6);
    pulse <= 1'h1;
    cyc(1);
    pulse <= 1'h0;
    if (clr_n) exp_q = d;
    cyc(9);
    din <= ~d;
    cyc(6);
    chk("true", q, exp_q[3:0]);
    chk("inverted", qn, ~exp_q[3:0]);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(16);
    reset_i <= 1'h0;
    cyc(2);
    capture(4'ha);
    $display("test start clear done");
    clr_n <= 1'h1;
    for (int i = 0; i < 12; i++)
      capture(4'($random(seed)));
    $display("test capture done");
    clr_n <= 1'h0;
    exp_q = 0;
    cyc(8);
    chk("cleared true", q, exp_q[3:0]);
    chk("cleared inverted", qn, ~exp_q[3:0]);
    capture(4'h5);
    $display("test clear done");
    print_verdict();
  end
endmodule // tb_quad_edge_register_clear
`default_nettype wire
